// [hw/pst_precip_interp.sv]
// precipitation settings interpreter: holds settings, runs counters and autosend
// assumes a parser in front that delivers one decoded command per cmd_valid pulse
module pst_precip_interp #(
    parameter int SEC_CYCLES = pst_pkg::SEC_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // decoded command
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] dev_addr,
    input wire logic cmd_sdi,
    // field writes of a change command
    input wire logic wr_sel,
    input wire logic [15:0] sel_val,
    input wire logic wr_interval,
    input wire logic [11:0] interval_val,
    input wire logic wr_units,
    input wire logic units_val,
    input wire logic wr_hail,
    input wire logic [1:0] hail_val,
    input wire logic wr_auto,
    input wire logic [1:0] auto_val,
    input wire logic wr_reset,
    input wire logic [1:0] reset_val,
    input wire logic wr_rlim,
    input wire logic [15:0] rlim_val,
    input wire logic wr_hlim,
    input wire logic [15:0] hlim_val,
    // sensor side
    input wire logic proto_auto,
    input wire logic rain_inc,
    input wire logic hail_inc,
    input wire logic precip_on,
    input wire logic rain_intensity_zero,
    // settings
    output logic [7:0] precip_sel,
    output logic [7:0] composite_sel,
    output logic [11:0] update_interval,
    output logic precip_units,
    output logic [1:0] hail_units,
    output logic [1:0] autosend_mode,
    output logic [1:0] reset_mode,
    output logic [15:0] rain_limit,
    output logic [15:0] hail_limit,
    // counters
    output logic [15:0] rain_amount,
    output logic [15:0] hail_amount,
    output logic [15:0] rain_duration,
    output logic intensity_clear,
    // messages and replies
    output logic msg_valid,
    output logic [1:0] msg_kind,
    output logic [15:0] msg_rain_amount,
    output logic [15:0] msg_hail_amount,
    output logic reply_valid,
    output logic [2:0] reply_op,
    output logic reply_report,
    output logic reply_refused
);
    localparam int SW = $clog2(SEC_CYCLES);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // a clear and an increment in one cycle leaves a count of one, so no hit is lost
    function automatic logic [15:0] next_count(input logic [15:0] cur, input logic inc,
            input logic clr, input logic [15:0] lim, input logic lim_en);
        logic [15:0] n;
        n = clr ? 16'h0000 : cur;
        if (inc) begin
            n = n + 16'h0001;
            if (lim_en && n >= lim) begin
                n = 16'h0000;
            end
        end
        return n;
    endfunction

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic addr_ok, is_change, poll, comp, clr_cmd;
    logic ivl_ok, rlim_ok, hlim_ok, hail_ok, auto_ok, refused;
    logic take_ivl, units_chg, hail_chg, reset_chg, immed_cmd, clear_all;
    assign addr_ok = cmd_valid && cmd_addr == dev_addr;
    assign is_change = addr_ok && cmd_op == pst_pkg::PST_OP_CHANGE;
    assign poll = addr_ok && cmd_op == pst_pkg::PST_OP_PRECIP_POLL;
    assign comp = addr_ok && cmd_op == pst_pkg::PST_OP_COMP_POLL;
    assign clr_cmd = addr_ok && cmd_op == pst_pkg::PST_OP_CLEAR;
    assign ivl_ok = interval_val >= pst_pkg::INTERVAL_MIN
        && interval_val <= pst_pkg::INTERVAL_MAX;
    assign rlim_ok = rlim_val >= pst_pkg::LIMIT_MIN;
    assign hlim_ok = hlim_val >= pst_pkg::LIMIT_MIN;
    assign hail_ok = hail_val != 2'h3;
    assign auto_ok = auto_val != 2'h3;
    assign refused = is_change && ((wr_interval && !ivl_ok) || (wr_rlim && !rlim_ok)
        || (wr_hlim && !hlim_ok) || (wr_hail && !hail_ok) || (wr_auto && !auto_ok));
    assign take_ivl = is_change && wr_interval && ivl_ok;
    assign units_chg = is_change && wr_units && units_val != precip_units;
    assign hail_chg = is_change && wr_hail && hail_ok && hail_val != hail_units;
    assign reset_chg = is_change && wr_reset && reset_val != reset_mode;
    assign immed_cmd = is_change && wr_reset
        && reset_val == pst_pkg::PST_RM_IMMED;

    // ----------------------------------------
    // settings
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            precip_sel <= pst_pkg::SEL_RST[15:8];
            composite_sel <= pst_pkg::SEL_RST[7:0];
            update_interval <= pst_pkg::INTERVAL_RST;
            precip_units <= pst_pkg::PST_PU_METRIC;
            hail_units <= pst_pkg::PST_HU_METRIC;
            autosend_mode <= pst_pkg::PST_AS_ONOFF;
            reset_mode <= pst_pkg::PST_RM_MANUAL;
            rain_limit <= pst_pkg::LIMIT_RST;
            hail_limit <= pst_pkg::LIMIT_RST;
        end else if (is_change) begin
            if (wr_sel) begin
                precip_sel <= sel_val[15:8];
                composite_sel <= sel_val[7:0];
            end
            if (take_ivl) begin
                update_interval <= interval_val;
            end
            if (wr_units) begin
                precip_units <= units_val;
            end
            if (wr_hail && hail_ok) begin
                hail_units <= hail_val;
            end
            if (wr_auto && auto_ok) begin
                autosend_mode <= auto_val;
            end
            if (wr_reset) begin
                reset_mode <= reset_val;
            end
            if (wr_rlim && rlim_ok) begin
                rain_limit <= rlim_val;
            end
            if (wr_hlim && hlim_ok) begin
                hail_limit <= hlim_val;
            end
        end
    end

    // ----------------------------------------
    // second tick and time-based interval
    // ----------------------------------------
    logic [SW-1:0] sec_cnt;
    logic sec_tick;
    logic [11:0] ivl_cnt;
    logic send_time;
    assign sec_tick = sec_cnt == SW'(SEC_CYCLES - 1);
    assign send_time = autosend_mode == pst_pkg::PST_AS_TIME && sec_tick
        && ivl_cnt >= update_interval - 12'h001;

    always_ff @(posedge mclk) begin
        if (rst || sec_tick) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_cnt + SW'(1);
        end
    end

    // restarting on a new interval avoids a burst of sends when it is shortened
    always_ff @(posedge mclk) begin
        if (rst || take_ivl || send_time) begin
            ivl_cnt <= 12'h000;
        end else if (sec_tick) begin
            ivl_cnt <= ivl_cnt + 12'h001;
        end
    end

    // ----------------------------------------
    // on/off event tracking
    // ----------------------------------------
    pst_pkg::pst_state_t state;
    logic [3:0] s10;
    logic step10, send_onoff;
    assign step10 = sec_tick && s10 == pst_pkg::ONOFF_DELAY_S - 4'h1;
    assign send_onoff = (state == pst_pkg::PST_ST_WAIT && step10)
        || (state == pst_pkg::PST_ST_RAIN && rain_intensity_zero);

    always_ff @(posedge mclk) begin
        if (rst || autosend_mode != pst_pkg::PST_AS_ONOFF) begin
            state <= pst_pkg::PST_ST_IDLE;
        end else begin
            unique case (state)
                pst_pkg::PST_ST_IDLE: begin
                    if (precip_on) begin
                        state <= pst_pkg::PST_ST_WAIT;
                    end
                end
                pst_pkg::PST_ST_WAIT: begin
                    if (step10) begin
                        state <= pst_pkg::PST_ST_RAIN;
                    end
                end
                pst_pkg::PST_ST_RAIN: begin
                    if (rain_intensity_zero) begin
                        state <= pst_pkg::PST_ST_IDLE;
                    end
                end
                default: state <= pst_pkg::PST_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || state == pst_pkg::PST_ST_IDLE || step10) begin
            s10 <= 4'h0;
        end else if (sec_tick) begin
            s10 <= s10 + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || clear_all || state == pst_pkg::PST_ST_IDLE) begin
            rain_duration <= 16'h0000;
        end else if (step10) begin
            rain_duration <= rain_duration + pst_pkg::DUR_STEP_S;
        end
    end

    // ----------------------------------------
    // autosend and messages
    // ----------------------------------------
    logic [3:0] tip_cnt;
    logic tip_fire, auto_fire, auto_pend, auto_req, precip_emit;
    assign tip_fire = rain_inc && tip_cnt == pst_pkg::TIP_STEP - 4'h1;
    // tip count runs in native units, so one step is 0.1 mm or 0.01 in alike
    assign auto_fire = proto_auto && (
        (autosend_mode == pst_pkg::PST_AS_TIP && tip_fire)
        || send_time
        || (autosend_mode == pst_pkg::PST_AS_ONOFF && send_onoff));
    // an autosend meeting a composite poll is held one cycle rather than dropped
    assign auto_req = auto_fire || auto_pend;
    assign precip_emit = poll || (auto_req && !comp);

    always_ff @(posedge mclk) begin
        if (rst || clear_all || tip_fire) begin
            tip_cnt <= 4'h0;
        end else if (rain_inc) begin
            tip_cnt <= tip_cnt + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            auto_pend <= 1'b0;
            msg_valid <= 1'b0;
            msg_kind <= pst_pkg::PST_MSG_AUTO;
            msg_rain_amount <= 16'h0000;
            msg_hail_amount <= 16'h0000;
        end else begin
            auto_pend <= auto_req && comp;
            msg_valid <= precip_emit || comp;
            if (comp) begin
                msg_kind <= pst_pkg::PST_MSG_COMP;
            end else if (poll) begin
                msg_kind <= pst_pkg::PST_MSG_POLL;
            end else begin
                msg_kind <= pst_pkg::PST_MSG_AUTO;
            end
            if (precip_emit || comp) begin
                msg_rain_amount <= rain_amount;
                msg_hail_amount <= hail_amount;
            end
        end
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    logic lim_en;
    assign lim_en = reset_mode == pst_pkg::PST_RM_LIMIT;
    assign clear_all = units_chg || hail_chg || reset_chg || immed_cmd || clr_cmd
        || (reset_mode == pst_pkg::PST_RM_AUTO && precip_emit);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rain_amount <= 16'h0000;
            hail_amount <= 16'h0000;
            intensity_clear <= 1'b0;
        end else begin
            rain_amount <= next_count(rain_amount, rain_inc, clear_all,
                rain_limit, lim_en);
            hail_amount <= next_count(hail_amount, hail_inc, clear_all,
                hail_limit, lim_en);
            intensity_clear <= hail_chg || reset_chg;
        end
    end

    // ----------------------------------------
    // command replies
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            reply_valid <= 1'b0;
            reply_op <= pst_pkg::PST_OP_QUERY;
            reply_report <= 1'b0;
            reply_refused <= 1'b0;
        end else begin
            reply_valid <= addr_ok && (cmd_op == pst_pkg::PST_OP_QUERY
                || is_change || clr_cmd);
            reply_op <= cmd_op;
            reply_report <= addr_ok && (cmd_op == pst_pkg::PST_OP_QUERY
                || (is_change && !cmd_sdi));
            reply_refused <= refused;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_wait_done;
        state == pst_pkg::PST_ST_WAIT && step10;
    endsequence
    sequence s_rain_started;
        state == pst_pkg::PST_ST_RAIN && rain_duration == pst_pkg::DUR_STEP_S;
    endsequence

    a_interval_kept: assert property (is_change && wr_interval && !ivl_ok |=>
        update_interval == $past(update_interval) ##0 reply_refused)
        else $error("out of range interval was taken");
    a_sel_split: assert property (is_change && wr_sel |=>
        precip_sel == $past(sel_val[15:8]) && composite_sel == $past(sel_val[7:0]))
        else $error("selection bits misplaced");
    a_unit_clear: assert property (units_chg && !rain_inc |=> rain_amount == 16'h0000)
        else $error("unit change kept the counter");
    a_mode_clear: assert property (reset_chg && !hail_inc |=>
        intensity_clear && hail_amount == 16'h0000)
        else $error("reset mode change did not clear");
    a_onoff_start: assert property (s_wait_done |=> s_rain_started)
        else $error("on/off event did not start");
    a_tip_send: assert property (autosend_mode == pst_pkg::PST_AS_TIP
        && proto_auto && tip_fire && !comp |=> msg_valid && msg_kind != pst_pkg::PST_MSG_COMP)
        else $error("no message at bucket tip");
    a_auto_gate: assert property (msg_valid && msg_kind == pst_pkg::PST_MSG_AUTO
        |-> $past(proto_auto) || $past(proto_auto, 2))
        else $error("autosend outside automatic protocol");
    a_manual_hold: assert property (reset_mode == pst_pkg::PST_RM_MANUAL
        && !clear_all && !rain_inc |=> rain_amount == $past(rain_amount))
        else $error("manual mode counter changed");
    a_auto_reset: assert property (reset_mode == pst_pkg::PST_RM_AUTO && poll
        && !rain_inc |=> rain_amount == 16'h0000 && msg_rain_amount == $past(rain_amount))
        else $error("auto reset lost or kept counts");
    a_limit_wrap: assert property (lim_en && rain_inc && !clear_all
        && rain_amount + 16'h0001 >= rain_limit |=> rain_amount == 16'h0000)
        else $error("rain counter passed its limit");
    a_immed_clear: assert property (immed_cmd && !hail_inc |=> hail_amount == 16'h0000)
        else $error("immediate reset did not clear");
    a_limit_range: assert property (rain_limit >= pst_pkg::LIMIT_MIN
        && hail_limit >= pst_pkg::LIMIT_MIN)
        else $error("limit below range");
endmodule

// [common/pst_pkg.sv]
// constants and types for the precipitation settings interpreter
// assumes a single 25 MHz clock and commands already parsed from the serial link
package pst_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 32'h0000_0028;
    localparam int SEC_NS = 32'h3B9A_CA00;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam logic [3:0] ONOFF_DELAY_S = 4'hA;
    localparam logic [15:0] DUR_STEP_S = 16'h000A;
    // ----------------------------------------
    // ranges and reset values
    // ----------------------------------------
    localparam logic [15:0] SEL_RST = 16'hFC80;
    localparam logic [11:0] INTERVAL_RST = 12'h03C;
    localparam logic [11:0] INTERVAL_MIN = 12'h001;
    localparam logic [11:0] INTERVAL_MAX = 12'hE10;
    localparam logic [15:0] LIMIT_RST = 16'h0064;
    localparam logic [15:0] LIMIT_MIN = 16'h0064;
    // counts per tipping-bucket step: 0.1 mm of 0.01 mm, or 0.01 in of 0.001 in
    localparam logic [3:0] TIP_STEP = 4'hA;
    // ----------------------------------------
    // enumerations
    // ----------------------------------------
    typedef enum logic [1:0] {
        PST_AS_ONOFF = 2'h0, PST_AS_TIP = 2'h1, PST_AS_TIME = 2'h2
    } pst_auto_t;
    typedef enum logic [1:0] {
        PST_RM_MANUAL = 2'h0, PST_RM_AUTO = 2'h1, PST_RM_LIMIT = 2'h2, PST_RM_IMMED = 2'h3
    } pst_rmode_t;
    typedef enum logic [1:0] {
        PST_HU_METRIC = 2'h0, PST_HU_IMPERIAL = 2'h1, PST_HU_HITS = 2'h2
    } pst_hunit_t;
    typedef enum logic {PST_PU_METRIC = 1'h0, PST_PU_IMPERIAL = 1'h1} pst_punit_t;
    typedef enum logic [2:0] {
        PST_OP_QUERY = 3'h0, PST_OP_CHANGE = 3'h1, PST_OP_CLEAR = 3'h2,
        PST_OP_PRECIP_POLL = 3'h3, PST_OP_COMP_POLL = 3'h4
    } pst_op_t;
    typedef enum logic [1:0] {
        PST_MSG_AUTO = 2'h0, PST_MSG_POLL = 2'h1, PST_MSG_COMP = 2'h2
    } pst_msg_t;
    typedef enum logic [1:0] {
        PST_ST_IDLE = 2'h0, PST_ST_WAIT = 2'h1, PST_ST_RAIN = 2'h3
    } pst_state_t;
endpackage

// [verif/pst_host_model.sv]
// host model: hands decoded commands to the interpreter, one per pulse
// assumes a running mclk; the bench calls send between edges
module pst_host_model (
    // clock
    input wire logic mclk,
    // command toward the device
    output logic cmd_valid,
    output logic [2:0] cmd_op,
    output logic [7:0] cmd_addr,
    output logic cmd_sdi,
    output logic [7:0] wr,
    output logic [15:0] val
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid, cmd_op, cmd_sdi, wr} = 13'h0;
        {cmd_addr, val} = 24'hFF_FFFF;
    end
    // address, code, then any number of field writes; a query carries none
    task automatic send(input logic [2:0] op, input logic [7:0] a, input logic s,
            input logic [7:0] w, input logic [15:0] v);
        @(negedge mclk);
        {cmd_valid, cmd_op, cmd_addr, cmd_sdi, wr, val} <= {1'b1, op, a, s, w, v};
        @(negedge mclk);
        // released lines other than cmd_sdi show the inverse so a stale value cannot pass
        {cmd_valid, cmd_op, cmd_addr, wr, val} <= {1'b0, ~op, ~a, ~w, ~v};
    endtask
endmodule

// [verif/tb_precip_settings_interpreter.sv]
// self-checking bench for the precipitation settings interpreter
// assumes the host model is compiled first; one second is shortened to 20 cycles
module tb_precip_settings_interpreter;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int SEC = 20;
    logic mclk, rst, cmd_valid, cmd_sdi, proto_auto, rain_inc, hail_inc, precip_on;
    logic rain_intensity_zero, precip_units, intensity_clear, msg_valid, reply_valid;
    logic reply_report, reply_refused;
    logic [2:0] cmd_op, reply_op;
    logic [7:0] cmd_addr, dev_addr, wr, precip_sel, composite_sel;
    logic [11:0] update_interval;
    logic [1:0] hail_units, autosend_mode, reset_mode, msg_kind;
    logic [15:0] val, rain_limit, hail_limit, rain_amount, hail_amount, rain_duration;
    logic [15:0] msg_rain_amount, msg_hail_amount;
    logic [1:0] hv[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic [23:0] exp_q[$];
    logic [31:0] seed, rv;
    int mismatches, tests_run, er, eh, n;
    pst_precip_interp #(.SEC_CYCLES(SEC)) dut (.*, .wr_sel(wr[0]), .sel_val(val),
        .wr_interval(wr[1]), .interval_val(val[11:0]), .wr_units(wr[2]), .units_val(val[0]),
        .wr_hail(wr[3]), .hail_val(val[1:0]), .wr_auto(wr[4]), .auto_val(val[1:0]),
        .wr_reset(wr[5]), .reset_val(val[1:0]), .wr_rlim(wr[6]), .rlim_val(val),
        .wr_hlim(wr[7]), .hlim_val(val));
    pst_host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_sdi(cmd_sdi), .wr(wr), .val(val));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [23:0] rep(input logic [2:0] op, input logic [2:0] f);
        return {1'b0, op, f, 17'h0};
    endfunction
    function automatic logic [23:0] msg(input logic [1:0] k, input logic c, input int a);
        return {2'b10, k, 3'h0, c, a[15:0]};
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // an unexpected result meets an unknown note and so always counts
    task automatic take(input logic [23:0] seen);
        logic [23:0] e;
        e = 'x;
        if (exp_q.size() > 0) e = exp_q.pop_front();
        if (e[16] !== 1'b1) seen[15:0] = e[15:0];
        e[16] = 1'b0;
        check({8'h0, seen}, {8'h0, e});
    endtask
    always @(negedge mclk) begin
        if (reply_valid === 1'b1)
            take({1'b0, reply_op, reply_report, reply_refused, intensity_clear, 17'h0});
        if (msg_valid === 1'b1)
            take({2'b10, msg_kind, 4'h0, msg_rain_amount});
    end
    task automatic cmd(input logic [2:0] op, input logic s, input logic [7:0] w,
            input logic [15:0] v, input logic [23:0] e);
        exp_q.push_back(e);
        host.send(op, 8'h00, s, w, v);
        @(negedge mclk);
    endtask
    task automatic inc(input int r, input int h);
        for (int i = 0; i < r || i < h; i++) begin
            @(negedge mclk);
            rain_inc = i < r;
            hail_inc = i < h;
        end
        @(negedge mclk);
        {rain_inc, hail_inc} = 2'h0;
        er += r;
        eh += h;
    endtask
    task automatic cnt();
        check({rain_amount, hail_amount}, {er[15:0], eh[15:0]});
    endtask
    task automatic wait_msg(output int k);
        k = 0;
        while (msg_valid !== 1'b1 && k < 400) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 400) check(32'h0, 32'h1);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // whole run is near 800 cycles, so 400 us means a hang
    initial begin
        #400us;
        mismatches++;
        final_report();
    end
    initial begin
        {rst, proto_auto, rain_inc, hail_inc, precip_on, rain_intensity_zero} = 6'h20;
        dev_addr = 8'h00;
        seed = 32'h0000_0009;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        check({precip_sel, composite_sel}, pst_pkg::SEL_RST);
        check(update_interval, pst_pkg::INTERVAL_RST);
        check({precip_units, hail_units, autosend_mode, reset_mode}, 32'h0);
        check({rain_limit, hail_limit}, {pst_pkg::LIMIT_RST, pst_pkg::LIMIT_RST});
        cnt();
        cmd(3'h0, 1'b0, 8'h00, 16'h0, rep(3'h0, 3'h4));
        host.send(3'h0, 8'h05, 1'b0, 8'h00, 16'h0);
        host.send(3'h5, 8'h00, 1'b0, 8'h00, 16'h0);
        cmd(3'h1, 1'b0, 8'h03, 16'h0E10, rep(3'h1, 3'h4));
        check({precip_sel, composite_sel, update_interval}, 28'h0E10E10);
        for (int i = 0; i < 4; i++) begin
            rv = xs();
            cmd(3'h1, 1'b1, 8'h01, rv[15:0], rep(3'h1, 3'h0));
            check({precip_sel, composite_sel}, rv[15:0]);
        end
        cmd(3'h0, 1'b1, 8'h00, 16'h0, rep(3'h0, 3'h4));
        cmd(3'h1, 1'b0, 8'h02, 16'h0000, rep(3'h1, 3'h6));
        cmd(3'h1, 1'b0, 8'h02, 16'h0E11, rep(3'h1, 3'h6));
        check(update_interval, 12'hE10);
        $display("test settings done");
        inc(3, 3);
        cmd(3'h1, 1'b0, 8'h04, 16'h0001, rep(3'h1, 3'h4));
        {er, eh} = 64'h0;
        check(precip_units, 1'b1);
        cnt();
        foreach (hv[i]) begin
            inc(1, 1);
            cmd(3'h1, 1'b0, 8'h18, {14'h0, hv[i]}, rep(3'h1, hv[i] == 2'h3 ? 3'h6 : 3'h5));
            if (hv[i] != 2'h3) {er, eh} = 64'h0;
            check({hail_units, autosend_mode}, hv[i] == 2'h3 ? 4'h0 : {2{hv[i]}});
            cnt();
        end
        $display("test units done");
        cmd(3'h1, 1'b0, 8'h20, 16'h0002, rep(3'h1, 3'h5));
        {er, eh} = 64'h0;
        cmd(3'h1, 1'b0, 8'hC0, 16'h0063, rep(3'h1, 3'h6));
        check({rain_limit, hail_limit}, {pst_pkg::LIMIT_MIN, pst_pkg::LIMIT_MIN});
        inc(99, 99);
        cnt();
        inc(1, 0);
        er = 0;
        cnt();
        inc(0, 1);
        eh = 0;
        cnt();
        cmd(3'h1, 1'b0, 8'h40, 16'hFFFF, rep(3'h1, 3'h4));
        check(rain_limit, 16'hFFFF);
        inc(3, 2);
        cmd(3'h1, 1'b0, 8'h20, 16'h0003, rep(3'h1, 3'h5));
        {er, eh} = 64'h0;
        cnt();
        cmd(3'h1, 1'b0, 8'h20, 16'h0001, rep(3'h1, 3'h5));
        inc(5, 4);
        cmd(3'h3, 1'b0, 8'h00, 16'h0, msg(2'h1, 1'b1, er));
        check(msg_hail_amount, eh[15:0]);
        {er, eh} = 64'h0;
        cnt();
        inc(2, 0);
        cmd(3'h4, 1'b0, 8'h00, 16'h0, msg(2'h2, 1'b1, er));
        cnt();
        cmd(3'h1, 1'b0, 8'h20, 16'h0000, rep(3'h1, 3'h5));
        {er, eh} = 64'h0;
        inc(4, 1);
        cmd(3'h3, 1'b0, 8'h00, 16'h0, msg(2'h1, 1'b1, er));
        cnt();
        cmd(3'h2, 1'b0, 8'h00, 16'h0, rep(3'h2, 3'h0));
        {er, eh} = 64'h0;
        cnt();
        $display("test reset modes done");
        // tipping bucket only sends while an automatic protocol runs
        proto_auto = 1'b1;
        cmd(3'h1, 1'b0, 8'h10, 16'h0001, rep(3'h1, 3'h4));
        exp_q.push_back(msg(2'h0, 1'b0, 0));
        inc(10, 0);
        repeat (3) @(negedge mclk);
        check(exp_q.size(), 32'h0);
        proto_auto = 1'b0;
        inc(10, 0);
        repeat (3) @(negedge mclk);
        cnt();
        cmd(3'h1, 1'b0, 8'h12, 16'h0002, rep(3'h1, 3'h4));
        repeat (3) exp_q.push_back(msg(2'h0, 1'b0, 0));
        proto_auto = 1'b1;
        wait_msg(n);
        @(negedge mclk);
        wait_msg(n);
        check(n + 1, 2 * SEC);
        @(negedge mclk);
        wait_msg(n);
        proto_auto = 1'b0;
        cmd(3'h1, 1'b0, 8'h10, 16'h0000, rep(3'h1, 3'h4));
        repeat (2) exp_q.push_back(msg(2'h0, 1'b0, 0));
        {proto_auto, precip_on} = 2'h3;
        wait_msg(n);
        check(n >= 9 * SEC && n <= 11 * SEC, 1'b1);
        @(negedge mclk);
        check(rain_duration, 16'h000A);
        repeat (10 * SEC + 4) @(negedge mclk);
        check(rain_duration, 16'h0014);
        rain_intensity_zero = 1'b1;
        wait_msg(n);
        repeat (2) @(negedge mclk);
        check(rain_duration, 16'h0000);
        {proto_auto, precip_on, rain_intensity_zero} = 3'h0;
        repeat (3) @(negedge mclk);
        check(exp_q.size(), 32'h0);
        $display("test autosend done");
        final_report();
    end
endmodule
